/* File: logic/touch_defs.svh */
/*
  Shared constants for the touch decision logic: timing, run length and
  bus address.
  Assumes a 40 MHz system clock; included by bare name.
*/
// Functional notes
// - channels are evaluated one at a time in a fixed repeating order.
// - the reference timing element starts together with every channel sample.
// - reference comparator trips first: one charge-up pulse for that channel.
// - channel comparator trips first: one charge-down pulse for that channel.
// - every charge pulse lasts a fixed number of clock cycles.
// - a per-channel counter counts successive pulses in one direction.
// - a direction change restarts the per-channel counter at one, counting the new pulse.
// - touch becomes active only after 64 consecutive charge-up pulses.
// - all eight touch outputs are mirrored in the sensor-state register.
// - any touch state change against the recorded state raises the interrupt.
// - sample rate comes from the oscillator, trimmed by the clock setting.
// - the device sleeps while the sleep input is held high.
// - the address-select pin gives the address low bit, 3Ah or 3Bh.
// - a clock output lets a cascaded secondary chip synchronise.
// - a secondary chip takes its timing from the cascade clock input.
// - reading the sensor-state register releases the interrupt output.
// - pin sleep ends only when the pin goes low, not by wake-up.
`ifndef TOUCH_DEFS_SVH
`define TOUCH_DEFS_SVH

`define TD_CHANNELS   8
`define TD_TOUCH_RUN  64
`define TD_CLK_NS     25
`define TD_PULSE_NS   250
`define TD_PULSE_CYC  ((`TD_PULSE_NS + `TD_CLK_NS - 1) / `TD_CLK_NS)
`define TD_WAIT_NS    10000
`define TD_WAIT_CYC   (`TD_WAIT_NS / `TD_CLK_NS)
`define TD_PRESCALE   16
`define TD_ADDR_HIGH  6'h1d

`endif

/* File: logic/touch_pkg.sv */
/*
  Types for the touch decision logic: sequencer states and the
  calibration drive bundle.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package touch_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PULSE} seq_t;

  typedef struct packed {
    logic       start;
    logic       up;
    logic       down;
    logic [2:0] chan;
  } cal_drive_t;
endpackage : touch_pkg

/* File: logic/touch_decision.sv */
/*
  Decision logic of an eight-channel capacitive touch sensor: channel
  scan, comparator race, calibration pulses, touch run counters,
  sensor-state mirror, interrupt, sleep and cascade clocking.
  Assumes comparator levels rise when the RC voltage falls below the
  reference and are synchronous to sys_clk_in, as are all other inputs.
*/
`timescale 1ns/100ps
`include "touch_defs.svh"

module touch_decision #(
  parameter int PRESCALE_BASE = `TD_PRESCALE,
  parameter int RUN_LEN       = `TD_TOUCH_RUN,
  parameter int PULSE_CYC     = `TD_PULSE_CYC,
  parameter int WAIT_CYC      = `TD_WAIT_CYC
) (
  // clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  // comparators
  input  wire logic                ref_cmp_in,
  input  wire logic                chan_cmp_in,
  // calibration drive
  output touch_pkg::cal_drive_t    drive_out,
  // configuration
  input  wire logic [4:0]          clock_setting_in,
  input  wire logic [7:0]          chan_mask_in,
  input  wire logic                secondary_mode_in,
  input  wire logic                address_select_pin_in,
  output logic      [6:0]          i2c_addr_out,
  // sensor state and interrupt
  output logic      [7:0]          channel_touch_outputs_out,
  output logic      [7:0]          sensor_state_register_out,
  input  wire logic                sensor_state_register_read_in,
  input  wire logic                cascade_int_n_in,
  output logic                     int_n_out,
  // sleep
  input  wire logic                sleep_pin_in,
  input  wire logic                sleep_cmd_in,
  input  wire logic                wake_cmd_in,
  output logic                     asleep_out,
  // cascade clock
  input  wire logic                cascade_clk_in,
  output logic                     cascade_clk_out
);

  localparam int TW = 10;

  // sequencer and timing state
  touch_pkg::seq_t   state_reg, state_next;
  logic [2:0]        chan_reg, chan_next;
  logic [TW-1:0]     timer_reg, timer_next;
  logic [TW-1:0]     presc_reg, presc_next;
  logic              start_reg, start_next;
  logic              dir_reg, dir_next;
  logic              div_reg, div_next;
  logic              cclk_d_reg, cclk_d_next;
  logic              sleep_cmd_reg, sleep_cmd_next;
  logic              asleep_reg, asleep_next;
  logic              tick;
  logic              ev_up;
  logic              ev_down;
  logic [TW-1:0]     period_m1;

  always_comb begin
    period_m1 = TW'((TW'(clock_setting_in) + TW'(1)) * TW'(PRESCALE_BASE)
                    - TW'(1));
    presc_next = (presc_reg >= period_m1) ? '0 : presc_reg + TW'(1);
    div_next = div_reg ^ (presc_reg >= period_m1);
    cclk_d_next = cascade_clk_in;
    if (secondary_mode_in) begin
      tick = cascade_clk_in & ~cclk_d_reg;
    end else begin
      tick = presc_reg >= period_m1;
    end
    sleep_cmd_next = sleep_cmd_reg;
    if (sleep_cmd_in) begin
      sleep_cmd_next = 1'b1;
    end else if (wake_cmd_in) begin
      sleep_cmd_next = 1'b0;
    end
    asleep_next = sleep_pin_in | sleep_cmd_next;
    state_next = state_reg;
    chan_next = chan_reg;
    timer_next = timer_reg;
    start_next = 1'b0;
    dir_next = dir_reg;
    ev_up = 1'b0;
    ev_down = 1'b0;
    case (state_reg)
      touch_pkg::ST_IDLE: begin
        if (tick && !asleep_reg) begin
          start_next = 1'b1;
          timer_next = '0;
          state_next = touch_pkg::ST_WAIT;
        end
      end
      touch_pkg::ST_WAIT: begin
        timer_next = timer_reg + TW'(1);
        if (ref_cmp_in && !chan_cmp_in && !chan_mask_in[chan_reg]) begin
          ev_up = 1'b1;
        end else if (chan_cmp_in && !ref_cmp_in
                     && !chan_mask_in[chan_reg]) begin
          ev_down = 1'b1;
        end
        if (ev_up || ev_down) begin
          dir_next = ev_up;
          timer_next = '0;
          state_next = touch_pkg::ST_PULSE;
        end else if (ref_cmp_in || chan_cmp_in
                     || timer_reg >= TW'(WAIT_CYC - 1)) begin
          chan_next = chan_reg + 3'h1;
          state_next = touch_pkg::ST_IDLE;
        end
      end
      touch_pkg::ST_PULSE: begin
        timer_next = timer_reg + TW'(1);
        if (timer_reg >= TW'(PULSE_CYC - 1)) begin
          chan_next = chan_reg + 3'h1;
          state_next = touch_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = touch_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= touch_pkg::ST_IDLE;
      chan_reg <= 3'h0;
      timer_reg <= '0;
      presc_reg <= '0;
      start_reg <= 1'b0;
      dir_reg <= 1'b0;
      div_reg <= 1'b0;
      cclk_d_reg <= 1'b0;
      sleep_cmd_reg <= 1'b0;
      asleep_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      timer_reg <= timer_next;
      presc_reg <= presc_next;
      start_reg <= start_next;
      dir_reg <= dir_next;
      div_reg <= div_next;
      cclk_d_reg <= cclk_d_next;
      sleep_cmd_reg <= sleep_cmd_next;
      asleep_reg <= asleep_next;
    end
  end

  // channel run counters, touch, mirror and interrupt
  logic [6:0]  cnt_reg [`TD_CHANNELS];
  logic [6:0]  cnt_next [`TD_CHANNELS];
  logic [7:0]  up_dir_reg, up_dir_next;
  logic [7:0]  touch_reg, touch_next;
  logic [7:0]  sensor_state_register_reg, sensor_state_register_next;
  logic        int_reg, int_next;

  always_comb begin
    cnt_next = cnt_reg;
    up_dir_next = up_dir_reg;
    touch_next = touch_reg & ~chan_mask_in;
    if (ev_up || ev_down) begin
      if (up_dir_reg[chan_reg] == ev_up) begin
        if (cnt_reg[chan_reg] < 7'(RUN_LEN)) begin
          cnt_next[chan_reg] = cnt_reg[chan_reg] + 7'h01;
        end
      end else begin
        cnt_next[chan_reg] = 7'h01;
      end
      up_dir_next[chan_reg] = ev_up;
      if (ev_up && cnt_next[chan_reg] == 7'(RUN_LEN)) begin
        touch_next[chan_reg] = 1'b1;
      end
      if (ev_down) begin
        touch_next[chan_reg] = 1'b0;
      end
    end
    sensor_state_register_next = touch_reg;
    // set wins over the read clear
    int_next = (touch_reg != sensor_state_register_reg)
               | (int_reg & ~sensor_state_register_read_in);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < `TD_CHANNELS; i++) begin
        cnt_reg[i] <= 7'h00;
      end
      up_dir_reg <= 8'h00;
      touch_reg <= 8'h00;
      sensor_state_register_reg <= 8'h00;
      int_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      up_dir_reg <= up_dir_next;
      touch_reg <= touch_next;
      sensor_state_register_reg <= sensor_state_register_next;
      int_reg <= int_next;
    end
  end

  assign drive_out.start = start_reg;
  assign drive_out.up = (state_reg == touch_pkg::ST_PULSE) & dir_reg;
  assign drive_out.down = (state_reg == touch_pkg::ST_PULSE) & ~dir_reg;
  assign drive_out.chan = chan_reg;
  assign channel_touch_outputs_out = touch_reg;
  assign sensor_state_register_out = sensor_state_register_reg;
  assign int_n_out = ~int_reg & cascade_int_n_in;
  assign asleep_out = asleep_reg;
  assign cascade_clk_out = div_reg;
  assign i2c_addr_out = {`TD_ADDR_HIGH, address_select_pin_in};

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_chan_order: assert property (
    $changed(chan_reg) |-> chan_reg == $past(chan_reg) + 3'h1)
    else $error("channel order broken");
  a_start_pair: assert property (
    start_reg |-> state_reg == touch_pkg::ST_WAIT && timer_reg == '0
      && $past(state_reg) == touch_pkg::ST_IDLE)
    else $error("reference start not paired with sample");
  a_up_cause: assert property (
    $rose(drive_out.up) |-> $past(ref_cmp_in && !chan_cmp_in))
    else $error("charge-up without reference first");
  a_down_cause: assert property (
    $rose(drive_out.down) |-> $past(chan_cmp_in && !ref_cmp_in))
    else $error("charge-down without channel first");
  a_pulse_width: assert property (
    $fell(drive_out.up | drive_out.down)
      |-> $past(timer_reg) == TW'(PULSE_CYC - 1))
    else $error("charge pulse width wrong");
  a_run_restart: assert property (
    (ev_up || ev_down) && up_dir_reg[chan_reg] != ev_up
      |=> cnt_reg[$past(chan_reg)] == 7'h01)
    else $error("run counter not cleared on turn");
  a_touch_run: assert property (
    $stable(chan_reg) && $rose(touch_reg[chan_reg])
      |-> cnt_reg[chan_reg] == 7'(RUN_LEN)
      && $past(ev_up))
    else $error("touch set before full run");
  a_sensor_state_register_mirror: assert property (
    sensor_state_register_reg == $past(touch_reg))
    else $error("sensor state not mirrored");
  a_int_change: assert property (
    touch_reg != sensor_state_register_reg
      |=> int_reg ##1 (int_reg || $past(sensor_state_register_read_in)))
    else $error("state change missed interrupt");
  a_int_read: assert property (
    sensor_state_register_read_in && touch_reg == sensor_state_register_reg |=> int_n_out == cascade_int_n_in)
    else $error("read did not release interrupt");
  a_pin_sleep: assert property (
    sleep_pin_in |=> asleep_out)
    else $error("pin sleep not held");

  c_touch: cover property ($stable(chan_reg) && $rose(touch_reg[chan_reg]));
  c_up_down: cover property (drive_out.up ##[1:200] drive_out.down);
  c_read_clear: cover property (!int_n_out ##1 sensor_state_register_read_in ##1 int_n_out);
  c_secondary: cover property (secondary_mode_in && start_reg);

endmodule : touch_decision

/* File: tb/comparator_model.sv */
/*
  Comparator pair seen by the touch decision logic: after each channel
  start, the reference or channel comparator trips as commanded.
  Assumes the bench drives mode_in (2 bits per channel) and delay_in.
*/
`timescale 1ns/100ps

module comparator_model (
  // clock and drive
  input  wire logic                 sys_clk_in,
  input  wire touch_pkg::cal_drive_t drive_in,
  // commanded behaviour: 01 ref first, 10 channel first, 00 none
  input  wire logic [15:0]          mode_in,
  input  wire logic [7:0]           delay_in,
  // comparator levels
  output logic                      ref_cmp_out = 1'b0,
  output logic                      chan_cmp_out = 1'b0
);
  logic [7:0] cnt_reg = 8'h00;
  logic [1:0] sel_reg = 2'h0;
  logic       armed_reg = 1'b0;

  always_ff @(posedge sys_clk_in) begin
    if (drive_in.start) begin
      ref_cmp_out  <= 1'b0;
      chan_cmp_out <= 1'b0;
      cnt_reg      <= delay_in;
      sel_reg      <= mode_in[drive_in.chan*2 +: 2];
      armed_reg    <= 1'b1;
    end else if (armed_reg && cnt_reg == 8'h00) begin
      ref_cmp_out  <= sel_reg[0];
      chan_cmp_out <= sel_reg[1];
      armed_reg    <= 1'b0;
    end else begin
      // trip is a short level, then the rc recharges
      ref_cmp_out  <= 1'b0;
      chan_cmp_out <= 1'b0;
      if (armed_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : comparator_model

/* File: tb/testbench.sv */
/*
  Self-checking bench for touch_decision with shortened counts.
  Assumes comparator_model as far side; no other surroundings.
*/
`timescale 1ns/100ps

module testbench;
  localparam int RUN = 4;
  localparam int PLS = 3;
  logic sys_clk = 0, rst = 1, sread = 0, cint_n = 1, sec = 0, asel = 0;
  logic slp_pin = 0, wake = 0, scmd = 0, cclk_in = 0, ref_cmp, chan_cmp;
  logic int_n, asleep, cclk_out;
  logic [6:0] addr;
  logic [7:0] touch, sensor_state_register, mask = 8'h00, dly = 8'h02;
  logic [15:0] mode = 16'h0000;
  touch_pkg::cal_drive_t drive;
  int mismatches = 0, compares = 0, cycles = 0, start_cnt = 0;

  touch_decision #(.PRESCALE_BASE(1), .RUN_LEN(RUN), .PULSE_CYC(PLS),
    .WAIT_CYC(20)) dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .ref_cmp_in(ref_cmp),
    .chan_cmp_in(chan_cmp), .drive_out(drive), .clock_setting_in(5'h00),
    .chan_mask_in(mask), .secondary_mode_in(sec),
    .address_select_pin_in(asel), .i2c_addr_out(addr),
    .channel_touch_outputs_out(touch), .sensor_state_register_out(sensor_state_register),
    .sensor_state_register_read_in(sread), .cascade_int_n_in(cint_n), .int_n_out(int_n),
    .sleep_pin_in(slp_pin), .sleep_cmd_in(scmd), .wake_cmd_in(wake),
    .asleep_out(asleep), .cascade_clk_in(cclk_in),
    .cascade_clk_out(cclk_out));

  comparator_model partner (.sys_clk_in(sys_clk), .drive_in(drive),
    .mode_in(mode), .delay_in(dly), .ref_cmp_out(ref_cmp),
    .chan_cmp_out(chan_cmp));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (drive.start === 1'b1) start_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic do_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
  endtask : do_reset

  task automatic get_start(output logic [2:0] ch);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (drive.start !== 1'b1 && n < 300);
    check({7'h00, drive.start}, 8'h01);
    ch = drive.chan;
  endtask : get_start

  task automatic pulse(output logic [1:0] dir, output int len);
    int n;
    n = 0;
    len = 0;
    while (!(drive.up | drive.down) && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    dir = {drive.down, drive.up};
    while ((drive.up | drive.down) && len < 40) begin
      @(posedge sys_clk);
      #1;
      len++;
    end
  endtask : pulse

  task automatic run_ch(input logic [2:0] c, input int times);
    logic [2:0] ch;
    logic [1:0] dir;
    int len;
    repeat (times) begin
      ch = ~c;
      for (int k = 0; k < 9 && ch !== c; k++) get_start(ch);
      pulse(dir, len);
      check({6'h00, dir}, mode[c*2 +: 2]);
    end
  endtask : run_ch

  task automatic t_reset();
    do_reset();
    check({2'h0, drive}, 8'h00);
    check({touch[6:0], int_n}, 8'h01);
    check({6'h00, asleep, cclk_out}, 8'h00);
    check({1'b0, addr}, 8'h3a);
    @(posedge sys_clk) asel <= 1'b1;
    #1 check({1'b0, addr}, 8'h3b);
    $display("reset test done");
  endtask : t_reset

  task automatic t_scan();
    logic [2:0] ch;
    logic [1:0] dir;
    int len;
    mode = 16'h9999;
    do_reset();
    for (int i = 0; i < 9; i++) begin
      get_start(ch);
      check({5'h00, ch}, i % 8);
      pulse(dir, len);
      check({6'h00, dir}, ch[0] ? 8'h02 : 8'h01);
      check(len[7:0], PLS);
    end
    $display("scan test done");
  endtask : t_scan

  task automatic t_touch();
    mode = 16'h0010;
    do_reset();
    run_ch(2, RUN - 1);
    check(touch, 8'h00);
    run_ch(2, 1);
    check(touch, 8'h04);
    check(sensor_state_register, 8'h04);
    check({7'h00, int_n}, 8'h00);
    @(posedge sys_clk) sread <= 1'b1;
    @(posedge sys_clk) sread <= 1'b0;
    #1 check({7'h00, int_n}, 8'h01);
    mode = 16'h0020;
    run_ch(2, 1);
    mode = 16'h0010;
    run_ch(2, RUN - 1);
    check(touch, 8'h00);
    run_ch(2, 1);
    check(touch, 8'h04);
    $display("touch test done");
  endtask : t_touch

  task automatic t_mask();
    mode = 16'h5555;
    @(posedge sys_clk) mask <= 8'h02;
    do_reset();
    run_ch(0, RUN + 1);
    check(touch, 8'hfd);
    @(posedge sys_clk) mask <= 8'h00;
    $display("mask test done");
  endtask : t_mask

  task automatic t_sleep();
    int n0;
    do_reset();
    @(posedge sys_clk) slp_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check({7'h00, asleep}, 8'h01);
    n0 = start_cnt;
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 check(start_cnt - n0, 8'h00);
    check({7'h00, asleep}, 8'h01);
    @(posedge sys_clk) slp_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check({7'h00, asleep}, 8'h00);
    @(posedge sys_clk) scmd <= 1'b1;
    @(posedge sys_clk) scmd <= 1'b0;
    #1 check({7'h00, asleep}, 8'h01);
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    #1 check({7'h00, asleep}, 8'h00);
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_cascade();
    int n0;
    mode = 16'h0000;
    do_reset();
    for (int n = 0; n < 50 && cclk_out !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check({7'h00, cclk_out}, 8'h01);
    @(posedge sys_clk) sec <= 1'b1;
    cint_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    #1 check({7'h00, int_n}, 8'h00);
    n0 = start_cnt;
    repeat (20) @(posedge sys_clk);
    #1 check(start_cnt - n0, 8'h00);
    @(posedge sys_clk) cclk_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check(start_cnt - n0, 8'h01);
    $display("cascade test done");
  endtask : t_cascade

  initial begin
    t_reset();
    t_scan();
    t_touch();
    t_mask();
    t_sleep();
    t_cascade();
    conclude();
  end
endmodule : testbench
